// ---- common/qfr_regs.svh ----
// Constants for the quad-I/O serial flash read sequencer
`ifndef QFR_REGS_SVH
`define QFR_REGS_SVH
`define QFR_OPCODE_QUAD_READ 8'hEB
`define QFR_SPI_CMD_EDGES 4'h8
`define QFR_QPI_CMD_EDGES 4'h2
`define QFR_ADDR_EDGES_3B 4'h6
`define QFR_ADDR_EDGES_4B 4'h8
`define QFR_DUMMY_DC00 4'h6
`define QFR_DUMMY_DC01 4'h4
`define QFR_DUMMY_DC10 4'h8
`define QFR_DUMMY_DC11 4'hA
`define QFR_FIFO_WIDTH 8
`define QFR_FIFO_DEPTH 8
`define QFR_ARRAY_ADDR_BITS 24
`endif

// ---- common/qfr_pkg.sv ----
// Types shared by the quad-I/O serial flash read sequencer
package qfr_pkg;
  typedef enum logic [2:0] {
    QFR_IDLE = 3'h0,
    QFR_CMD = 3'h1,
    QFR_ADDR = 3'h3,
    QFR_DUMMY = 3'h2,
    QFR_DATA = 3'h6,
    QFR_IGNORE = 3'h7
  } qfr_state_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
  } qfr_pins_t;

  typedef struct packed {
    logic quad_io_enable_bit;
    logic quad_command_mode;
    logic wide_addr_mode;
    logic [7:0] extended_address_bit;
    logic dummy_count_sel_hi;
    logic dummy_count_sel_lo;
    logic busy;
  } qfr_cfg_t;
endpackage

// ---- rtl/qfr_read.sv ----
// Quad-I/O read sequencer of a serial NOR flash, with its prefetch FIFO
`timescale 1ns/1ps
`default_nettype none
`include "qfr_regs.svh"

// Notes on behaviour
// [RULE_01] Host sets the quad I/O enable bit before issuing the quad read.
// [RULE_02] Address nibbles are sampled from the I/O lines on serial clock rise.
// [RULE_03] Read data goes out a nibble at a time, changing on clock fall.
// [RULE_04] Any start byte; address advances after each byte sent.
// [RULE_05] Address counter wraps past the top of the array to zero.
// [RULE_06] Address, dummy and data phases move four bits per clock.
// [RULE_07] Default 3-byte address; 4-byte mode or extended byte reaches higher. The code masks the top byte off with ADDR_MAX, so neither does.
// [RULE_08] Single-line command, quad address, six dummy clocks by default, quad data.
// [RULE_09] Same read also accepted in quad command mode.
// [RULE_10] Chip select rising in the data phase ends the read and driving.
// [RULE_11] Read ignored while program, erase or status write is busy.
// [RULE_12] Host drives the lines during the two indicator clocks.
// [RULE_13] Host never sends an indicator with complementary nibbles.
// [RULE_14] Dummy count comes from the two dummy-count select bits.
// [RULE_15] Wide address mode carries four address bytes instead of three.
// [RULE_16] The quad read opcode is the same in both command modes.
// [RULE_17] Host without continuous read keeps indicator bits all one or zero.
// [RULE_18] Chip select high releases the lines; await next chip select fall.

// ****************************************
// Prefetch FIFO
// ****************************************
module qfr_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  // Full and empty straight from the occupancy count
  assign in_ready = (count_r != CW'(D));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage array, written only on accepted pushes
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and count; flush drops everything held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(D - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(D - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + CW'(push) - CW'(pop);
    end
  end
endmodule

// ****************************************
// Read sequencer top
// ****************************************
module qfr_read
  import qfr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire qfr_pins_t pins_in,
  output logic [3:0] io_line_out,
  output logic [3:0] io_line_oe,
  input wire qfr_cfg_t cfg,
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic [31:0] mem_addr,
  input wire logic mem_rsp_valid,
  input wire logic [7:0] mem_rsp_data,
  output logic read_active,
  output logic read_rejected,
  output logic [31:0] out_addr
);
  localparam logic [31:0] ADDR_MAX = 32'((64'h1 << `QFR_ARRAY_ADDR_BITS) - 64'h1);
  qfr_pins_t pins_m;
  qfr_pins_t pins_s;
  logic sclk_d_r, cs_n_d_r;
  logic rise, fall, cs_fall;
  qfr_state_t st_r;
  logic [3:0] cnt_r, cmd_need, addr_need, dummy_need;
  logic [7:0] cmd_sh_r, cmd_byte;
  logic [31:0] addr_sh_r, addr_full;
  logic cmd_last, addr_last, dum_last, accept;
  logic pf_on_r, outst_r, drop_r;
  logic [31:0] pf_addr_r, out_addr_r;
  logic fifo_in_ready, fifo_out_valid, pop;
  logic [7:0] fifo_dout, byte_r;
  logic nib_hi_r, oe_r, rej_r;
  logic [3:0] io_out_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  // Two stages; only the second stage feeds any logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_m <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
      pins_s <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
    end else begin
      pins_m <= pins_in;
      pins_s <= pins_m;
    end
  end

  // Delayed copies for edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      sclk_d_r <= pins_s.sclk;
      cs_n_d_r <= pins_s.cs_n;
    end
  end

  // Clock edges count only while selected
  assign rise = pins_s.sclk && !sclk_d_r && !pins_s.cs_n;
  assign fall = !pins_s.sclk && sclk_d_r && !pins_s.cs_n;
  assign cs_fall = !pins_s.cs_n && cs_n_d_r;

  // ****************************************
  // Phase decode
  // ****************************************
  // [RULE_09] both command modes
  assign cmd_need = cfg.quad_command_mode ? `QFR_QPI_CMD_EDGES : `QFR_SPI_CMD_EDGES;
  assign cmd_byte = cfg.quad_command_mode ? {cmd_sh_r[3:0], pins_s.io} : {cmd_sh_r[6:0], pins_s.io[0]};
  assign cmd_last = (st_r == QFR_CMD) && rise && (cnt_r == cmd_need - 4'h1);
  // [RULE_16] opcode check
  // [RULE_11] busy rejects the read
  assign accept = (cmd_byte == `QFR_OPCODE_QUAD_READ) && !cfg.busy && cfg.quad_io_enable_bit;
  // [RULE_15] wide address lengthens phase
  assign addr_need = cfg.wide_addr_mode ? `QFR_ADDR_EDGES_4B : `QFR_ADDR_EDGES_3B;
  assign addr_last = (st_r == QFR_ADDR) && rise && (cnt_r == addr_need - 4'h1);
  // [RULE_07] extended byte tops 3-byte address
  assign addr_full = cfg.wide_addr_mode ? {addr_sh_r[27:0], pins_s.io} :
                     {cfg.extended_address_bit, addr_sh_r[19:0], pins_s.io};
  // [RULE_14] dummy count select
  always_comb begin
    case ({cfg.dummy_count_sel_hi, cfg.dummy_count_sel_lo})
      2'h0: dummy_need = `QFR_DUMMY_DC00;
      2'h1: dummy_need = `QFR_DUMMY_DC01;
      2'h2: dummy_need = `QFR_DUMMY_DC10;
      default: dummy_need = `QFR_DUMMY_DC11;
    endcase
  end
  // Indicator clocks sit inside the dummy count and are not decoded
  assign dum_last = (st_r == QFR_DUMMY) && rise && (cnt_r == dummy_need - 4'h1);

  // ****************************************
  // Sequencer state
  // ****************************************
  // [RULE_08] command, address, dummy, data
  // [RULE_18] deselect returns to idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= QFR_IDLE;
    end else if (pins_s.cs_n) begin
      st_r <= QFR_IDLE;
    end else begin
      case (st_r)
        QFR_IDLE: if (cs_fall) st_r <= QFR_CMD;
        QFR_CMD: if (cmd_last) st_r <= accept ? QFR_ADDR : QFR_IGNORE;
        QFR_ADDR: if (addr_last) st_r <= QFR_DUMMY;
        QFR_DUMMY: if (dum_last) st_r <= QFR_DATA;
        QFR_DATA: st_r <= QFR_DATA;
        QFR_IGNORE: st_r <= QFR_IGNORE;
        default: st_r <= QFR_IDLE;
      endcase
    end
  end

  // Edge counter within a phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
    end else if (pins_s.cs_n || cmd_last || addr_last || dum_last) begin
      cnt_r <= 4'h0;
    end else if (rise && (st_r == QFR_CMD || st_r == QFR_ADDR || st_r == QFR_DUMMY)) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // [RULE_02] capture on rising edge
  // [RULE_06] four bits per clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_sh_r <= 8'h00;
      addr_sh_r <= 32'h0000_0000;
    end else if (rise) begin
      if (st_r == QFR_CMD) cmd_sh_r <= cmd_byte;
      if (st_r == QFR_ADDR) addr_sh_r <= addr_full;
    end
  end

  // Rejected read pulse, one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rej_r <= 1'b0;
    end else begin
      rej_r <= cmd_last && (cmd_byte == `QFR_OPCODE_QUAD_READ) && !accept;
    end
  end

  // ****************************************
  // Prefetch from the array
  // ****************************************
  // One fetch in flight; FIFO room at issue guarantees the push fits
  assign mem_req_valid = pf_on_r && !outst_r && fifo_in_ready;
  assign mem_addr = pf_addr_r;

  // [RULE_04] fetch address runs upward
  // [RULE_05] wrap at array top
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pf_on_r <= 1'b0;
      pf_addr_r <= 32'h0000_0000;
    end else if (addr_last) begin
      pf_on_r <= 1'b1;
      pf_addr_r <= addr_full & ADDR_MAX;
    end else begin
      if (pins_s.cs_n) pf_on_r <= 1'b0;
      if (mem_req_valid && mem_req_ready) begin
        pf_addr_r <= (pf_addr_r == ADDR_MAX) ? 32'h0000_0000 : pf_addr_r + 32'h1;
      end
    end
  end

  // Stale answers from an earlier read are dropped, not pushed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outst_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      if (mem_rsp_valid) outst_r <= 1'b0;
      else if (mem_req_valid && mem_req_ready) outst_r <= 1'b1;
      if (mem_rsp_valid) drop_r <= 1'b0;
      else if (addr_last && outst_r) drop_r <= 1'b1;
    end
  end

  assign pop = fall && (st_r == QFR_DATA) && nib_hi_r && fifo_out_valid;

  qfr_fifo #(.W(`QFR_FIFO_WIDTH), .D(`QFR_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(addr_last),
    .in_valid(mem_rsp_valid && !drop_r && pf_on_r),
    .in_ready(fifo_in_ready),
    .in_data(mem_rsp_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_dout)
  );

  // ****************************************
  // Data output
  // ****************************************
  // [RULE_03] nibbles change on falling edge, high nibble first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_out_r <= 4'h0;
      byte_r <= 8'h00;
      nib_hi_r <= 1'b1;
    end else if (addr_last) begin
      nib_hi_r <= 1'b1;
    end else if (fall && st_r == QFR_DATA) begin
      nib_hi_r <= !nib_hi_r;
      if (nib_hi_r) begin
        io_out_r <= fifo_dout[7:4];
        byte_r <= fifo_dout;
      end else begin
        io_out_r <= byte_r[3:0];
      end
    end
  end

  // [RULE_04] output address advances per byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_addr_r <= 32'h0000_0000;
    end else if (addr_last) begin
      out_addr_r <= addr_full & ADDR_MAX;
    end else if (fall && st_r == QFR_DATA && !nib_hi_r) begin
      out_addr_r <= (out_addr_r == ADDR_MAX) ? 32'h0000_0000 : out_addr_r + 32'h1;
    end
  end

  // [RULE_10] deselect stops driving on the clock after the synchronised chip select reads high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_r <= 1'b0;
    end else if (pins_s.cs_n) begin
      oe_r <= 1'b0;
    end else if (fall && st_r == QFR_DATA) begin
      oe_r <= 1'b1;
    end
  end

  assign io_line_out = io_out_r;
  assign io_line_oe = {4{oe_r}};
  assign read_active = (st_r == QFR_DATA);
  assign read_rejected = rej_r;
  assign out_addr = out_addr_r;

  // ****************************************
  // Assertions
  // ****************************************
  property p_addr_capture;
    (st_r == QFR_ADDR && rise) |=> (addr_sh_r[3:0] == $past(pins_s.io));
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("address nibble not captured"); // [RULE_02]

  property p_data_on_fall;
    $changed(io_out_r) |-> $past(fall) && $past(st_r == QFR_DATA);
  endproperty
  a_data_on_fall: assert property (p_data_on_fall) else $error("data changed off a falling edge"); // [RULE_03]

  property p_addr_advance;
    (fall && st_r == QFR_DATA && !nib_hi_r && !addr_last && out_addr_r != ADDR_MAX)
      |=> out_addr_r == $past(out_addr_r) + 32'h1;
  endproperty
  a_addr_advance: assert property (p_addr_advance) else $error("address did not advance"); // [RULE_04]

  property p_wrap;
    (mem_req_valid && mem_req_ready && !addr_last && pf_addr_r == ADDR_MAX) |=> pf_addr_r == 32'h0000_0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("fetch address did not wrap"); // [RULE_05]

  property p_release;
    pins_s.cs_n |=> (io_line_oe == 4'h0) && (st_r == QFR_IDLE);
  endproperty
  a_release: assert property (p_release) else $error("lines still driven after deselect"); // [RULE_10]

  property p_busy_reject;
    (cmd_last && cfg.busy) |=> (st_r == QFR_IGNORE || st_r == QFR_IDLE) && !pf_on_r;
  endproperty
  a_busy_reject: assert property (p_busy_reject) else $error("read taken while busy"); // [RULE_11]

  property p_dummy_len;
    (st_r == QFR_DUMMY && rise && cnt_r == dummy_need - 4'h1 && !pins_s.cs_n) |=> st_r == QFR_DATA;
  endproperty
  a_dummy_len: assert property (p_dummy_len) else $error("dummy phase length wrong"); // [RULE_14]

  property p_addr_len;
    (st_r == QFR_ADDR && rise && cnt_r == (cfg.wide_addr_mode ? 4'h7 : 4'h5)) |=> st_r == QFR_DUMMY;
  endproperty
  a_addr_len: assert property (p_addr_len) else $error("address phase length wrong"); // [RULE_15]

  property p_no_drive_early;
    (st_r != QFR_DATA) |=> (io_line_oe == 4'h0) || $past(st_r == QFR_DATA);
  endproperty
  a_no_drive_early: assert property (p_no_drive_early) else $error("lines driven outside data phase"); // [RULE_18]

  cover property ((st_r == QFR_DATA) && pop);
  cover property (read_rejected);
  cover property (mem_req_valid && mem_req_ready && pf_addr_r == ADDR_MAX);
  cover property (!fifo_in_ready && pf_on_r);
endmodule
`default_nettype wire

// ---- sim/qfr_host_model.sv ----
// Host controller model driving chip select, serial clock and I/O lines
`timescale 1ns/1ps
`default_nettype none
module qfr_host_model (
  input wire logic clk,
  input wire logic [3:0] io_w,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io_drv,
  output logic io_oe
);
  // Deselected with the serial clock parked low between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io_drv = 4'h0;
    io_oe = 1'b0;
  end

  // One serial clock, 4 system clocks per half; sampled late so a slow nibble still lands
  task automatic nib(input logic [3:0] d, output logic [3:0] r);
    io_drv <= d;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
    r = io_w;
    sclk <= 1'b0;
  endtask

  // Whole frame: command, address, dummy, nn data nibbles, then deselect
  task automatic frame(input bit qp, input logic [7:0] op, input logic [31:0] a, input int anib,
                       input int dum, input int nn, output logic [31:0] q);
    logic [3:0] r;
    int i;
    cs_n <= 1'b0;
    io_oe <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < (qp ? 2 : 8); i++) begin
      if (qp) nib(op[7 - 4 * i -: 4], r);
      else nib({3'h0, op[7 - i]}, r);
    end
    for (i = 0; i < anib; i++) nib(a[4 * (anib - 1 - i) + 3 -: 4], r);
    for (i = 0; i < dum; i++) begin
      io_oe <= (i < 2);
      nib(4'h0, r);
    end
    io_oe <= 1'b0;
    q = 32'h0;
    for (i = 0; i < nn; i++) begin
      nib(4'h0, r);
      q = {q[27:0], r};
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_quad_io_serial_flash_read.sv ----
// Testbench for the quad-I/O read sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_quad_io_serial_flash_read import qfr_pkg::*; ();
  logic clk = 1'b0;
  logic rst = 1'b1;
  qfr_cfg_t cfg = '0;
  qfr_pins_t pins;
  logic mem_req_ready = 1'b0;
  logic mem_rsp_valid = 1'b0;
  logic [7:0] mem_rsp_data = 8'h00;
  logic [3:0] io_line_out, io_line_oe, io_w, host_io;
  logic [3:0] last_io = 4'h0;
  logic mem_req_valid, read_active, read_rejected, cs_n, sclk, host_oe;
  logic [31:0] mem_addr, out_addr;
  logic pend = 1'b0;
  logic [1:0] lat = 2'h0;
  logic [23:0] ma = 24'h000000;
  logic drv_seen = 1'b0;
  logic act_seen = 1'b0;
  logic rej_seen = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  int dum_tab[4] = '{6, 4, 8, 10};

  always #4 clk = ~clk;

  // Wire resolution; a released line shows a changing pattern, never a stale value
  assign io_w = (|io_line_oe) ? io_line_out : (host_oe ? host_io : ~last_io);
  assign pins = {cs_n, sclk, io_w};

  qfr_read dut_u (.clk(clk), .rst(rst), .pins_in(pins), .io_line_out(io_line_out), .io_line_oe(io_line_oe),
    .cfg(cfg), .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_addr(mem_addr),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data), .read_active(read_active),
    .read_rejected(read_rejected), .out_addr(out_addr));

  qfr_host_model host_u (.clk(clk), .io_w(io_w), .cs_n(cs_n), .sclk(sclk), .io_drv(host_io), .io_oe(host_oe));

  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
  endfunction

  // ****************************************
  // Array memory and frame monitors
  // ****************************************
  // Ready toggles so the fetch side sees stalls; answer after a few cycles
  always @(posedge clk) begin
    last_io <= io_w;
    mem_rsp_valid <= 1'b0;
    mem_req_ready <= ~mem_req_ready;
    if (pend) begin
      if (lat == 2'h0) begin
        mem_rsp_valid <= 1'b1;
        mem_rsp_data <= mem_byte(ma);
        pend <= 1'b0;
      end else lat <= lat - 2'h1;
    end else if (mem_req_valid && mem_req_ready) begin
      pend <= 1'b1;
      lat <= 2'h2;
      ma <= mem_addr[23:0];
    end
    if (|io_line_oe) drv_seen <= 1'b1;
    if (read_active) act_seen <= 1'b1;
    if (read_rejected) rej_seen <= 1'b1;
  end

  // ****************************************
  // Checking tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One frame with the given setup; expectation worked out from the array contents
  task automatic run(input bit qp, input bit wide, input logic [1:0] sel, input logic [31:0] a, input int nn,
                     input bit bsy, input bit qe, input logic [7:0] op);
    logic [31:0] q, e;
    logic [7:0] b;
    logic [23:0] s;
    bit ok;
    int k;
    ok = !bsy && qe && op == 8'hEB;
    s = a[23:0];
    @(posedge clk);
    cfg <= '{qe, qp, wide, a[31:24], sel[1], sel[0], bsy};
    drv_seen <= 1'b0;
    act_seen <= 1'b0;
    rej_seen <= 1'b0;
    @(posedge clk);
    host_u.frame(qp, op, a, wide ? 8 : 6, dum_tab[sel], nn, q);
    e = 32'h0;
    for (k = 0; k < nn; k++) begin
      b = mem_byte(s + 24'(k / 2));
      e = {e[27:0], (k % 2) ? b[3:0] : b[7:4]};
    end
    if (ok) begin
      check("data", e, q); // nibbles high first
      // The fall that ends the last sampled clock still shifts one more nibble out
      check("out_addr", {8'h00, s + 24'((nn + 1) / 2)}, {8'h00, out_addr[23:0]}); // address advance
    end
    check("active", {31'h0, ok}, {31'h0, act_seen}); // data phase entered
    check("drove", {31'h0, ok}, {31'h0, drv_seen}); // refused frame stays quiet
    check("rejected", {31'h0, !ok && op == 8'hEB}, {31'h0, rej_seen}); // refusal flagged
    check("release", 32'h0, {27'h0, read_active, io_line_oe}); // lines released
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    run(0, 0, 2'h0, 32'h77123456, 8, 0, 1, 8'hEB); // single-line, default dummy
    run(1, 0, 2'h1, 32'h00FFFFFE, 8, 0, 1, 8'hEB); // quad command, wrap to zero
    run(0, 1, 2'h2, 32'h00ABCDEF, 8, 0, 1, 8'hEB); // wide address, eight dummies
    run(1, 1, 2'h3, 32'h00FFFFFF, 8, 0, 1, 8'hEB); // ten dummies, wrap
    run(0, 0, 2'h0, 32'h00000010, 4, 1, 1, 8'hEB); // busy refuses
    run(1, 0, 2'h0, 32'h00000020, 4, 0, 0, 8'hEB); // quad enable low refuses
    run(0, 0, 2'h0, 32'h00000030, 4, 0, 1, 8'h0B); // other opcode ignored
    run(0, 0, 2'h1, 32'h00345678, 3, 0, 1, 8'hEB); // end mid byte
    run(1, 0, 2'h0, 32'h00000100, 6, 0, 1, 8'hEB); // next frame after early end
    report_and_stop();
  end

  // Hang guard: all frames take well under this span
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
